// [verilog/sdram_ctrl_regs.svh]
`ifndef SDRAM_CTRL_REGS_SVH
`define SDRAM_CTRL_REGS_SVH

// ==========================================================
// Clocking
`define SD_CLK_NS        100
`define SD_DIV           2

// ==========================================================
// Power-up wait and refresh spacing
`define SD_INIT_US       981
`define SD_INIT_CYC      ((`SD_INIT_US * 1000 + `SD_CLK_NS - 1) / `SD_CLK_NS)
`define SD_REF_NS        15600
`define SD_REF_CYC       (`SD_REF_NS / `SD_CLK_NS)
`define SD_REF_MARGIN    24

// ==========================================================
// Row timing and burst length in memory clock cycles, last init refresh index
`define SD_TRCD          3'd1
`define SD_TRAS          3'd5
`define SD_TRC           3'd7
`define SD_TRP           3'd2
`define SD_TMRD          3'd2
`define SD_BL            3'd4
`define SD_INIT_REF_LAST 3'd7

// ==========================================================
// Read capture window, in memory cycles after the read command
`define SD_RD_FIRST      3'd4
`define SD_RD_LAST       3'd7

// ==========================================================
// Mode word, size probe
`define SD_MODE_WORD     12'h0022
`define SD_PROBE_ROW     12'h0800
`define SD_PROBE_MARK    16'ha5a5
`define SD_A10_BIT       10

`endif

// [verilog/sdram_ctrl_pkg.sv]
package sdram_ctrl_pkg;

	typedef enum logic [3:0] {
		CMD_MRS = 4'h0,
		CMD_REF = 4'h1,
		CMD_PRE = 4'h2,
		CMD_ACT = 4'h3,
		CMD_WR  = 4'h4,
		CMD_RD  = 4'h5,
		CMD_NOP = 4'h7
	} sd_cmd_t;

	typedef enum {
		S_POWER,
		S_PRE_ALL,
		S_INIT_REF,
		S_MODE,
		S_ACCESS,
		S_PROBE_WAIT,
		S_IDLE,
		S_REFRESH,
		S_SELF,
		S_EXIT
	} ctrl_state_t;

endpackage : sdram_ctrl_pkg

// [verilog/camera_sdram_controller.sv]
`timescale 1ns/1ps
`default_nettype none
`include "sdram_ctrl_regs.svh"

// Behaviour
// - Memory data path is 16 bits, one word per data beat.
// - Supports 1M x 16 and 4M x 16, probes size itself, adapts addressing.
// - Drives the memory clock, nominally 5 MHz.
// - Row active exactly 5 cycles, activate spacing 7, precharge 2.
// - At least one cycle between activate and read or write.
// - Image data is read in bursts.
// - Image data is written in bursts.
// - Refreshes never more than 15.6 us apart while active.
// - Standby puts the memory into self-refresh.
// - No own refresh commands while in self-refresh.
// - 981 us initialisation wait after power-up before accesses.
module camera_sdram_controller #(
	parameter int unsigned DATA_W      = 16,
	parameter int unsigned ADDR_W      = 22,
	parameter int unsigned INIT_CYCLES = `SD_INIT_CYC
) (
	// Clock, reset, enable
	input  wire logic              ref_clk,
	input  wire logic              rst_n,
	input  wire logic              clk_en,
	// Power state
	input  wire logic              standby_req,
	output logic                   in_standby,
	output logic                   init_done,
	output logic                   mem_4m,
	// Burst requests
	input  wire logic              req_valid,
	output logic                   req_ready,
	input  wire logic              req_write,
	input  wire logic [ADDR_W-1:0] req_addr,
	// Write beats
	input  wire logic [DATA_W-1:0] wr_data,
	output logic                   wr_ready,
	// Read beats
	output logic [DATA_W-1:0]      rd_data,
	output logic                   rd_valid,
	// Memory pins
	output logic                   sd_clk,
	output logic                   sd_cke,
	output logic                   sd_cs_n,
	output logic                   sd_ras_n,
	output logic                   sd_cas_n,
	output logic                   sd_we_n,
	output logic [1:0]             sd_ba,
	output logic [11:0]            sd_addr,
	output logic [1:0]             sd_dqm,
	output logic [DATA_W-1:0]      sd_dq_o,
	output logic                   sd_dq_oe,
	input  wire logic [DATA_W-1:0] sd_dq_i
);
	import sdram_ctrl_pkg::*;

	localparam int unsigned IW = $clog2(INIT_CYCLES + 1);

	if (DATA_W != 16 || ADDR_W != 22 || INIT_CYCLES < 2) begin : g_bad_param
		$error("camera_sdram_controller: unsupported parameter values");
	end

	// ==========================================================
	// Data pin synchroniser
	logic [DATA_W-1:0] dq_s1_q;
	logic [DATA_W-1:0] dq_s2_q;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			dq_s1_q <= '0;
			dq_s2_q <= '0;
		end else if (clk_en) begin
			dq_s1_q <= sd_dq_i;
			dq_s2_q <= dq_s1_q;
		end
	end

	// ==========================================================
	// Controller state
	ctrl_state_t       st_q,        st_d;
	logic              phase_q,     phase_d;
	logic [2:0]        cyc_q,       cyc_d;
	logic [2:0]        refs_q,      refs_d;
	logic [1:0]        probe_q,     probe_d;
	logic [IW-1:0]     init_cnt_q,  init_cnt_d;
	logic [7:0]        ref_cnt_q,   ref_cnt_d;
	logic [2:0]        rd_cnt_q,    rd_cnt_d;
	logic              cap_prb_q,   cap_prb_d;
	logic              op_wr_q,     op_wr_d;
	logic              op_prb_q,    op_prb_d;
	logic [11:0]       op_row_q,    op_row_d;
	logic [1:0]        op_ba_q,     op_ba_d;
	logic [7:0]        op_col_q,    op_col_d;
	logic              done_q,      done_d;
	logic              m4_q,        m4_d;
	logic              stby_q,      stby_d;
	logic              cke_q,       cke_d;
	sd_cmd_t           cmd_q,       cmd_d;
	logic [1:0]        ba_q,        ba_d;
	logic [11:0]       addr_q,      addr_d;
	logic [DATA_W-1:0] dq_o_q,      dq_o_d;
	logic              dq_oe_q,     dq_oe_d;
	logic [DATA_W-1:0] rd_data_q,   rd_data_d;
	logic              rd_valid_q,  rd_valid_d;

	logic tick;
	logic ref_due;
	logic last_cyc;

	always_comb begin
		tick      = phase_q;
		ref_due   = ref_cnt_q >= 8'(`SD_REF_CYC - `SD_REF_MARGIN);
		last_cyc  = cyc_q == `SD_TRC - 3'd1;
		req_ready = tick && st_q == S_IDLE && !ref_due && !standby_req;
		wr_ready  = tick && st_q == S_ACCESS && op_wr_q && !op_prb_q
			&& cyc_q >= `SD_TRCD && cyc_q <= `SD_TRCD + `SD_BL - 3'd1;

		st_d       = st_q;
		phase_d    = ~phase_q;
		cyc_d      = cyc_q;
		refs_d     = refs_q;
		probe_d    = probe_q;
		init_cnt_d = init_cnt_q;
		ref_cnt_d  = (ref_cnt_q == 8'hff) ? ref_cnt_q : ref_cnt_q + 8'd1;
		rd_cnt_d   = rd_cnt_q;
		cap_prb_d  = cap_prb_q;
		op_wr_d    = op_wr_q;
		op_prb_d   = op_prb_q;
		op_row_d   = op_row_q;
		op_ba_d    = op_ba_q;
		op_col_d   = op_col_q;
		done_d     = done_q;
		m4_d       = m4_q;
		stby_d     = stby_q;
		cke_d      = cke_q;
		cmd_d      = cmd_q;
		ba_d       = ba_q;
		addr_d     = addr_q;
		dq_o_d     = dq_o_q;
		dq_oe_d    = dq_oe_q;
		rd_data_d  = rd_data_q;
		rd_valid_d = 1'b0;

		if (st_q == S_POWER) begin
			init_cnt_d = init_cnt_q + IW'(1);
		end

		// Memory pins change only as the memory clock falls, so setup and hold are a half period
		if (tick) begin
			cmd_d   = CMD_NOP;
			dq_oe_d = 1'b0;
			cyc_d   = cyc_q + 3'd1;

			// Fixed capture slots cover CAS latency plus the pin synchroniser
			if (rd_cnt_q != 3'd0) begin
				rd_cnt_d = (rd_cnt_q == `SD_RD_LAST) ? 3'd0 : rd_cnt_q + 3'd1;
				if (rd_cnt_q >= `SD_RD_FIRST) begin
					if (cap_prb_q) begin
						if (rd_cnt_q == `SD_RD_FIRST) begin
							m4_d = dq_s2_q != `SD_PROBE_MARK;
						end
					end else begin
						rd_valid_d = 1'b1;
						rd_data_d  = dq_s2_q;
					end
				end
			end

			unique case (st_q)
				S_POWER: begin
					cyc_d = 3'd0;
					if (init_cnt_q >= IW'(INIT_CYCLES - 1)) begin
						st_d = S_PRE_ALL;
					end
				end
				S_PRE_ALL: begin
					if (cyc_q == 3'd0) begin
						cmd_d                = CMD_PRE;
						addr_d               = 12'h000;
						addr_d[`SD_A10_BIT]  = 1'b1;
					end
					if (cyc_q == `SD_TRP - 3'd1) begin
						st_d  = S_INIT_REF;
						cyc_d = 3'd0;
					end
				end
				S_INIT_REF: begin
					if (cyc_q == 3'd0) begin
						cmd_d     = CMD_REF;
						ref_cnt_d = 8'd0;
					end
					if (last_cyc) begin
						cyc_d  = 3'd0;
						refs_d = refs_q + 3'd1;
						if (refs_q == `SD_INIT_REF_LAST) begin
							st_d = S_MODE;
						end
					end
				end
				S_MODE: begin
					if (cyc_q == 3'd0) begin
						cmd_d  = CMD_MRS;
						ba_d   = 2'b00;
						addr_d = `SD_MODE_WORD;
					end
					if (cyc_q == `SD_TMRD - 3'd1) begin
						st_d     = S_ACCESS;
						cyc_d    = 3'd0;
						probe_d  = 2'd0;
						op_prb_d = 1'b1;
						op_wr_d  = 1'b1;
						op_row_d = 12'h000;
						op_ba_d  = 2'b00;
						op_col_d = 8'h00;
					end
				end
				S_ACCESS: begin
					if (cyc_q == 3'd0) begin
						cmd_d  = CMD_ACT;
						ba_d   = op_ba_q;
						addr_d = op_row_q;
					end
					if (cyc_q == `SD_TRCD) begin
						cmd_d  = op_wr_q ? CMD_WR : CMD_RD;
						ba_d   = op_ba_q;
						addr_d = {4'h0, op_col_q};
						if (!op_wr_q) begin
							rd_cnt_d  = 3'd1;
							cap_prb_d = op_prb_q;
						end
					end
					if (op_wr_q && cyc_q >= `SD_TRCD && cyc_q <= `SD_TRCD + `SD_BL - 3'd1) begin
						dq_oe_d = 1'b1;
						if (op_prb_q) begin
							dq_o_d = (probe_q == 2'd1) ? `SD_PROBE_MARK : '0;
						end else begin
							dq_o_d = wr_data;
						end
					end
					if (cyc_q == `SD_TRAS) begin
						cmd_d  = CMD_PRE;
						ba_d   = op_ba_q;
						addr_d = 12'h000;
					end
					if (last_cyc) begin
						cyc_d = 3'd0;
						if (!op_prb_q) begin
							st_d = S_IDLE;
						end else if (probe_q == 2'd0) begin
							// A 1M part ignores row bit 11, so the mark lands on row 0
							probe_d  = 2'd1;
							op_row_d = `SD_PROBE_ROW;
						end else if (probe_q == 2'd1) begin
							probe_d  = 2'd2;
							op_wr_d  = 1'b0;
							op_row_d = 12'h000;
						end else begin
							st_d = S_PROBE_WAIT;
						end
					end
				end
				S_PROBE_WAIT: begin
					cyc_d = 3'd0;
					if (rd_cnt_q == 3'd0) begin
						st_d   = S_IDLE;
						done_d = 1'b1;
					end
				end
				S_IDLE: begin
					cyc_d = 3'd0;
					if (ref_due) begin
						st_d = S_REFRESH;
					end else if (standby_req) begin
						cmd_d     = CMD_REF;
						cke_d     = 1'b0;
						stby_d    = 1'b1;
						st_d      = S_SELF;
					end else if (req_valid) begin
						st_d     = S_ACCESS;
						op_prb_d = 1'b0;
						op_wr_d  = req_write;
						op_col_d = {req_addr[7:2], 2'b00};
						if (m4_q) begin
							op_row_d = req_addr[19:8];
							op_ba_d  = req_addr[21:20];
						end else begin
							op_row_d = {1'b0, req_addr[18:8]};
							op_ba_d  = {1'b0, req_addr[19]};
						end
					end
				end
				S_REFRESH: begin
					if (cyc_q == 3'd0) begin
						cmd_d     = CMD_REF;
						ref_cnt_d = 8'd0;
					end
					if (last_cyc) begin
						st_d  = S_IDLE;
						cyc_d = 3'd0;
					end
				end
				S_SELF: begin
					cyc_d     = 3'd0;
					ref_cnt_d = 8'd0;
					if (!standby_req) begin
						cke_d = 1'b1;
						st_d  = S_EXIT;
					end
				end
				S_EXIT: begin
					if (last_cyc) begin
						stby_d = 1'b0;
						st_d   = S_REFRESH;
						cyc_d  = 3'd0;
					end
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_q       <= S_POWER;
			phase_q    <= 1'b0;
			cyc_q      <= 3'd0;
			refs_q     <= 3'd0;
			probe_q    <= 2'd0;
			init_cnt_q <= '0;
			ref_cnt_q  <= 8'd0;
			rd_cnt_q   <= 3'd0;
			cap_prb_q  <= 1'b0;
			op_wr_q    <= 1'b0;
			op_prb_q   <= 1'b0;
			op_row_q   <= 12'h000;
			op_ba_q    <= 2'b00;
			op_col_q   <= 8'h00;
			done_q     <= 1'b0;
			m4_q       <= 1'b0;
			stby_q     <= 1'b0;
			cke_q      <= 1'b1;
			cmd_q      <= CMD_NOP;
			ba_q       <= 2'b00;
			addr_q     <= 12'h000;
			dq_o_q     <= '0;
			dq_oe_q    <= 1'b0;
			rd_data_q  <= '0;
			rd_valid_q <= 1'b0;
		end else if (clk_en) begin
			st_q       <= st_d;
			phase_q    <= phase_d;
			cyc_q      <= cyc_d;
			refs_q     <= refs_d;
			probe_q    <= probe_d;
			init_cnt_q <= init_cnt_d;
			ref_cnt_q  <= ref_cnt_d;
			rd_cnt_q   <= rd_cnt_d;
			cap_prb_q  <= cap_prb_d;
			op_wr_q    <= op_wr_d;
			op_prb_q   <= op_prb_d;
			op_row_q   <= op_row_d;
			op_ba_q    <= op_ba_d;
			op_col_q   <= op_col_d;
			done_q     <= done_d;
			m4_q       <= m4_d;
			stby_q     <= stby_d;
			cke_q      <= cke_d;
			cmd_q      <= cmd_d;
			ba_q       <= ba_d;
			addr_q     <= addr_d;
			dq_o_q     <= dq_o_d;
			dq_oe_q    <= dq_oe_d;
			rd_data_q  <= rd_data_d;
			rd_valid_q <= rd_valid_d;
		end
	end

	// ==========================================================
	// Pin drive
	assign sd_clk     = phase_q;
	assign sd_cke     = cke_q;
	assign sd_cs_n    = cmd_q[3];
	assign sd_ras_n   = cmd_q[2];
	assign sd_cas_n   = cmd_q[1];
	assign sd_we_n    = cmd_q[0];
	assign sd_ba      = ba_q;
	assign sd_addr    = addr_q;
	assign sd_dqm     = 2'b00;
	assign sd_dq_o    = dq_o_q;
	assign sd_dq_oe   = dq_oe_q;
	assign rd_data    = rd_data_q;
	assign rd_valid   = rd_valid_q;
	assign in_standby = stby_q;
	assign init_done  = done_q;
	assign mem_4m     = m4_q;

endmodule : camera_sdram_controller

`default_nettype wire

// [testbench/camera_sdram_controller_checker.sv]
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Memory command timing checks
module camera_sdram_controller_checker
	import sdram_ctrl_pkg::*;
#(
	parameter int unsigned INIT_CYCLES = 20
) (
	// Clock, reset
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic clk_en,
	// Power state and requests
	input wire logic standby_req,
	input wire logic in_standby,
	input wire logic init_done,
	input wire logic req_ready,
	// Memory pins
	input wire logic sd_clk,
	input wire logic sd_cke,
	input wire logic sd_cs_n,
	input wire logic sd_ras_n,
	input wire logic sd_cas_n,
	input wire logic sd_we_n,
	input wire logic sd_dq_oe
);
	logic [3:0]  cmd;
	logic [3:0]  cmd_q;
	logic [7:0]  ag_q;
	logic [7:0]  rg_q;
	logic [15:0] pw_q;
	logic        seen_q;
	logic        wake_q;
	logic        act_start;
	logic        ref_start;
	logic        pre_start;
	assign cmd = {sd_cs_n, sd_ras_n, sd_cas_n, sd_we_n};
	assign act_start = cmd == CMD_ACT && cmd_q != CMD_ACT;
	assign ref_start = cmd == CMD_REF && cmd_q != CMD_REF;
	assign pre_start = cmd == CMD_PRE && cmd_q != CMD_PRE;
	// Saturating counts so long idle spans never wrap into a false pass
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			cmd_q  <= 4'h7;
			ag_q   <= 8'hff;
			rg_q   <= 8'h00;
			pw_q   <= 16'h0000;
			seen_q <= 1'b0;
			wake_q <= 1'b0;
		end else begin
			cmd_q  <= cmd;
			ag_q   <= act_start ? 8'h00 : (ag_q == 8'hff ? ag_q : ag_q + 8'h01);
			// Self-refresh keeps the cells, so the gap count restarts on wake-up
			rg_q   <= (ref_start || in_standby) ? 8'h00
				: (rg_q == 8'hff ? rg_q : rg_q + 8'h01);
			pw_q   <= pw_q == 16'hffff ? pw_q : pw_q + 16'h0001;
			seen_q <= seen_q || cmd != CMD_NOP;
			wake_q <= (ref_start && sd_cke) ? 1'b0 : (wake_q || !sd_cke);
		end
	end
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	clk_toggle_a: assert property (clk_en |=> sd_clk != $past(sd_clk))
		else $error("memory clock stuck");
	row_active_a: assert property (act_start |-> ##10 cmd == CMD_PRE)
		else $error("row not closed after five cycles");
	act_spacing_a: assert property (act_start |-> ag_q >= 8'd13)
		else $error("activates too close");
	precharge_a: assert property (pre_start |-> ##2 (cmd != CMD_ACT && cmd != CMD_REF)[*2])
		else $error("precharge too short");
	act_to_cmd_a: assert property (act_start |-> ##2 (cmd == CMD_RD || cmd == CMD_WR))
		else $error("no access one cycle after activate");
	wr_drive_a: assert property (cmd == CMD_WR && cmd_q != CMD_WR |-> sd_dq_oe[*8])
		else $error("write burst not driven four beats");
	ref_gap_a: assert property (init_done && sd_cke && !in_standby && !ref_start |-> rg_q <= 8'd154)
		else $error("refresh gap too long");
	self_enter_a: assert property ($fell(sd_cke) |-> (cmd == CMD_REF) ##[0:2] in_standby)
		else $error("bad self-refresh entry");
	self_quiet_a: assert property (!sd_cke && !$past(sd_cke) && cmd_q != CMD_REF |-> cmd == CMD_NOP)
		else $error("command during self-refresh");
	power_wait_a: assert property (32'(pw_q) + 1 < INIT_CYCLES |-> cmd == CMD_NOP)
		else $error("command during power-up wait");
	ready_gate_a: assert property (req_ready |-> init_done && !standby_req && !in_standby)
		else $error("request accepted too early");
	init_order_a: assert property (!seen_q && cmd != CMD_NOP |-> cmd == CMD_PRE)
		else $error("init does not start with precharge");
	wake_a: assert property ($rose(sd_cke) |-> (cmd != CMD_ACT)[*8])
		else $error("access right after wake-up");
	wake_ref_a: assert property (act_start |-> !wake_q)
		else $error("access before wake-up refresh");
endmodule : camera_sdram_controller_checker

bind camera_sdram_controller camera_sdram_controller_checker #(.INIT_CYCLES(INIT_CYCLES)) u_chk (
	.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en), .standby_req(standby_req),
	.in_standby(in_standby), .init_done(init_done), .req_ready(req_ready), .sd_clk(sd_clk),
	.sd_cke(sd_cke), .sd_cs_n(sd_cs_n), .sd_ras_n(sd_ras_n), .sd_cas_n(sd_cas_n),
	.sd_we_n(sd_we_n), .sd_dq_oe(sd_dq_oe));
`default_nettype wire

// [testbench/sdram_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Behavioural 16-bit memory, latency 2, bursts of 4
module sdram_model (
	// Size strap, high for 4M x 16
	input wire logic        fit_4m,
	// Memory pins
	input wire logic        sd_clk,
	input wire logic        sd_cke,
	input wire logic        sd_cs_n,
	input wire logic        sd_ras_n,
	input wire logic        sd_cas_n,
	input wire logic        sd_we_n,
	input wire logic [1:0]  sd_ba,
	input wire logic [11:0] sd_addr,
	input wire logic [15:0] sd_dq_o,
	output logic [15:0]     sd_dq_i
);
	logic [15:0] mem [int];
	logic [11:0] row [4];
	logic [21:0] key;
	int          wa;
	int          wc = 0;
	int          ra;
	int          rs = 0;
	initial sd_dq_i = 16'h0000;
	always @(posedge sd_clk) begin
		// Small part ignores the top row bit, so rows alias
		key = {sd_ba, fit_4m ? row[sd_ba] : {1'b0, row[sd_ba][10:0]}, sd_addr[7:0]};
		// Idle bus flips every cycle so stale data never looks valid
		if (rs >= 3 && rs <= 6) begin
			sd_dq_i <= mem[ra];
			ra++;
		end else begin
			sd_dq_i <= ~sd_dq_i;
		end
		if (rs != 0) rs = rs == 6 ? 0 : rs + 1;
		if (wc != 0) begin
			mem[wa] = sd_dq_o;
			wa++;
			wc--;
		end
		if (sd_cke) begin
			case ({sd_cs_n, sd_ras_n, sd_cas_n, sd_we_n})
				4'h3: row[sd_ba] = sd_addr;
				4'h4: begin
					mem[key] = sd_dq_o;
					wa = key + 1;
					wc = 3;
				end
				4'h5: begin
					ra = key;
					rs = 2;
				end
				default: ;
			endcase
		end
	end
endmodule : sdram_model
`default_nettype wire

// [testbench/camera_sdram_controller_bench.sv]
`timescale 1ns/1ps
`default_nettype none
module camera_sdram_controller_bench;
	localparam int unsigned INIT = 20;
	localparam logic [21:0] ADR_A = 22'h2a_1b44;
	localparam logic [21:0] ADR_B = 22'h22_1b44;
	localparam logic [21:0] ADR_C = 22'h1a_1b44;
	logic fit_4m;
	logic ref_clk, rst_n, clk_en, standby_req, in_standby, init_done, mem_4m;
	logic req_valid, req_ready, req_write, wr_ready, rd_valid, sd_dq_oe;
	logic sd_clk, sd_cke, sd_cs_n, sd_ras_n, sd_cas_n, sd_we_n;
	logic [21:0] req_addr;
	logic [15:0] wr_data, rd_data, sd_dq_o, sd_dq_i;
	logic [1:0] sd_ba, sd_dqm;
	logic [11:0] sd_addr;
	int bad_count = 0;
	int total_checks = 0;
	camera_sdram_controller #(.INIT_CYCLES(INIT)) u_camera_sdram_controller (
		.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en), .standby_req(standby_req),
		.in_standby(in_standby), .init_done(init_done), .mem_4m(mem_4m),
		.req_valid(req_valid), .req_ready(req_ready), .req_write(req_write),
		.req_addr(req_addr), .wr_data(wr_data), .wr_ready(wr_ready), .rd_data(rd_data),
		.rd_valid(rd_valid), .sd_clk(sd_clk), .sd_cke(sd_cke), .sd_cs_n(sd_cs_n),
		.sd_ras_n(sd_ras_n), .sd_cas_n(sd_cas_n), .sd_we_n(sd_we_n), .sd_ba(sd_ba),
		.sd_addr(sd_addr), .sd_dqm(sd_dqm), .sd_dq_o(sd_dq_o), .sd_dq_oe(sd_dq_oe),
		.sd_dq_i(sd_dq_i));
	sdram_model u_sdram_model (.fit_4m(fit_4m), .sd_clk(sd_clk), .sd_cke(sd_cke),
		.sd_cs_n(sd_cs_n), .sd_ras_n(sd_ras_n), .sd_cas_n(sd_cas_n), .sd_we_n(sd_we_n),
		.sd_ba(sd_ba), .sd_addr(sd_addr), .sd_dq_o(sd_dq_o), .sd_dq_i(sd_dq_i));
	// ==========================================================
	// Shared tasks
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : give_verdict
	task automatic burst(input logic wr, input logic [21:0] adr, input logic [15:0] base);
		int n;
		int i;
		n = 0;
		i = 0;
		@(negedge ref_clk);
		req_valid = 1'b1;
		req_write = wr;
		req_addr = adr;
		wr_data = base;
		#1;
		while (req_ready !== 1'b1 && n < 300) begin
			@(negedge ref_clk);
			#1;
			n++;
		end
		@(negedge ref_clk);
		req_valid = 1'b0;
		while (i < 4 && n < 300) begin
			#1;
			n++;
			if (wr && wr_ready === 1'b1) i++;
			if (!wr && rd_valid === 1'b1) begin
				check(rd_data, base + 16'(i));
				i++;
			end
			@(negedge ref_clk);
			wr_data = base + 16'(i);
		end
		check(16'(i), 16'h0004);
	endtask : burst
	// ==========================================================
	// Scenarios
	task automatic t_init();
		int n;
		n = 0;
		while (init_done !== 1'b1 && n < 3000) begin
			@(negedge ref_clk);
			n++;
		end
		check(16'(n >= INIT), 16'h0001);
		check(16'(mem_4m), 16'h0001);
	endtask : t_init
	task automatic t_traffic();
		burst(1'b1, ADR_A, 16'h1230);
		burst(1'b1, ADR_B, 16'hbee0);
		burst(1'b0, ADR_A, 16'h1230);
		burst(1'b0, ADR_B, 16'hbee0);
		check(16'(sd_dqm), 16'h0000);
	endtask : t_traffic
	task automatic t_freeze();
		logic held;
		@(negedge ref_clk);
		clk_en = 1'b0;
		held = sd_clk;
		repeat (4) @(negedge ref_clk);
		check(16'(sd_clk), 16'(held));
		clk_en = 1'b1;
		repeat (3) @(negedge ref_clk);
		check(16'(sd_clk ^ held), 16'h0001);
	endtask : t_freeze
	task automatic t_refresh();
		repeat (600) @(negedge ref_clk);
		burst(1'b0, ADR_A, 16'h1230);
	endtask : t_refresh
	task automatic t_standby();
		int n;
		n = 0;
		standby_req = 1'b1;
		while (in_standby !== 1'b1 && n < 300) begin
			@(negedge ref_clk);
			n++;
		end
		check(16'(sd_cke), 16'h0000);
		repeat (500) @(negedge ref_clk);
		check(16'(sd_cke), 16'h0000);
		standby_req = 1'b0;
		while (in_standby !== 1'b0 && n < 600) begin
			@(negedge ref_clk);
			n++;
		end
		check(16'(sd_cke), 16'h0001);
		burst(1'b0, ADR_B, 16'hbee0);
	endtask : t_standby
	// Small part: second reset, probe must find 1M, top address bits ignored
	task automatic t_small_part();
		int n;
		n = 0;
		@(negedge ref_clk);
		rst_n = 1'b0;
		fit_4m = 1'b0;
		repeat (20) @(negedge ref_clk);
		rst_n = 1'b1;
		while (init_done !== 1'b1 && n < 3000) begin
			@(negedge ref_clk);
			n++;
		end
		check(16'(mem_4m), 16'h0000);
		burst(1'b1, ADR_A, 16'h5670);
		burst(1'b0, ADR_A, 16'h5670);
		burst(1'b0, ADR_C, 16'h5670);
	endtask : t_small_part
	// ==========================================================
	// Clock, watchdog, main sequence
	initial begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end
	initial begin
		#(100 * 20000);
		bad_count++;
		give_verdict();
	end
	initial begin
		rst_n = 1'b0;
		fit_4m = 1'b1;
		clk_en = 1'b1;
		standby_req = 1'b0;
		req_valid = 1'b0;
		req_write = 1'b0;
		req_addr = '0;
		wr_data = '0;
		repeat (20) @(negedge ref_clk);
		rst_n = 1'b1;
		t_init();
		t_traffic();
		t_freeze();
		t_refresh();
		t_standby();
		t_small_part();
		give_verdict();
	end
endmodule : camera_sdram_controller_bench
`default_nettype wire
